// [ssdsu_lanes.sv]
// Combinational lane arithmetic: byte and halfword subtracts, SAD sum
`include "ssdsu_params.svh"
module ssdsu_lanes
   import ssdsu_pkg::*;
(
   input wire logic [`SSDSU_XLEN-1:0] a_val,
   input wire logic [`SSDSU_XLEN-1:0] b_val,
   output logic [`SSDSU_XLEN-1:0] sub8_res,
   output logic [`SSDSU_GE_W-1:0] sub8_ge,
   output logic [`SSDSU_XLEN-1:0] sub16_res,
   output logic [`SSDSU_GE_W-1:0] sub16_ge,
   output logic [`SSDSU_XLEN-1:0] sad_sum
);
   // Nine-bit difference, top bit is the borrow
   function automatic logic [8:0] byte_diff(input logic [7:0] x,
                                            input logic [7:0] y);
      byte_diff = {1'b0, x} - {1'b0, y};
   endfunction

   function automatic logic [7:0] byte_absdiff(input logic [7:0] x,
                                               input logic [7:0] y);
      byte_absdiff = (x >= y) ? x - y : y - x;
   endfunction

   wire [16:0] hd_lo = {1'b0, a_val[`SSDSU_HALF_LO]} -
                       {1'b0, b_val[`SSDSU_HALF_LO]};
   wire [16:0] hd_hi = {1'b0, a_val[`SSDSU_HALF_HI]} -
                       {1'b0, b_val[`SSDSU_HALF_HI]};
   wire [8:0] bd0 = byte_diff(a_val[7:0], b_val[7:0]);
   wire [8:0] bd1 = byte_diff(a_val[15:8], b_val[15:8]);
   wire [8:0] bd2 = byte_diff(a_val[23:16], b_val[23:16]);
   wire [8:0] bd3 = byte_diff(a_val[31:24], b_val[31:24]);
   wire [9:0] ad_sum = {2'h0, byte_absdiff(a_val[7:0], b_val[7:0])} +
                       {2'h0, byte_absdiff(a_val[15:8], b_val[15:8])} +
                       {2'h0, byte_absdiff(a_val[23:16], b_val[23:16])} +
                       {2'h0, byte_absdiff(a_val[31:24], b_val[31:24])};

   assign sub16_res = {hd_hi[15:0], hd_lo[15:0]};
   assign sub16_ge = {{2{~hd_hi[16]}}, {2{~hd_lo[16]}}};
   assign sub8_res = {bd3[7:0], bd2[7:0], bd1[7:0], bd0[7:0]};
   assign sub8_ge = {~bd3[8], ~bd2[8], ~bd1[8], ~bd0[8]};
   assign sad_sum = {22'h000000, ad_sum};
endmodule

// [ssdsu_params.svh]
// Constants for the packed byte/halfword subtract and SAD unit
`ifndef SSDSU_PARAMS_SVH
`define SSDSU_PARAMS_SVH
`define SSDSU_XLEN 32
`define SSDSU_REG_IDX_W 4
`define SSDSU_SP_IDX 4'hD
`define SSDSU_PC_IDX 4'hF
`define SSDSU_GE_W 4
`define SSDSU_GE_RST 4'h0
`define SSDSU_WORD_ZERO 32'h0000_0000
`define SSDSU_HALF_LO 15:0
`define SSDSU_HALF_HI 31:16
`endif

// [ssdsu_pkg.sv]
// Types for the packed byte/halfword subtract and SAD unit
`include "ssdsu_params.svh"
package ssdsu_pkg;
   typedef enum logic [2:0] {
      SSDSU_OP_NONE = 3'h0,
      SSDSU_OP_SAD = 3'h1,
      SSDSU_OP_SADA = 3'h2,
      SSDSU_OP_SUB16 = 3'h3,
      SSDSU_OP_SUB8 = 3'h4,
      SSDSU_OP_SEL = 3'h5
   } ssdsu_op_t;

   typedef struct packed {
      logic valid;
      ssdsu_op_t op;
      logic condition_true;
      logic dest_given;
      logic [`SSDSU_REG_IDX_W-1:0] dest_reg;
      logic [`SSDSU_REG_IDX_W-1:0] first_src_reg;
      logic [`SSDSU_XLEN-1:0] first_val;
      logic [`SSDSU_XLEN-1:0] second_val;
      logic [`SSDSU_XLEN-1:0] accum_val;
   } ssdsu_issue_t;

   typedef struct packed {
      logic wr_en;
      logic [`SSDSU_REG_IDX_W-1:0] wr_reg;
      logic [`SSDSU_XLEN-1:0] wr_data;
   } ssdsu_wb_t;
endpackage

// [ssdsu_rf_model.sv]
// Register file and decoder model that feeds the unit and takes results
module ssdsu_rf_model
   import ssdsu_pkg::*;
(
   input wire logic core_clk,
   input wire logic req_valid,
   input wire ssdsu_op_t req_op,
   input wire logic req_cond,
   input wire logic req_dg,
   input wire logic [3:0] req_d,
   input wire logic [3:0] req_n,
   input wire logic [3:0] req_m,
   input wire logic [3:0] req_a,
   input wire ssdsu_wb_t wb,
   output ssdsu_issue_t issue
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] rf [16];

   // Bypass so a result is usable by the very next instruction
   function automatic logic [31:0] rd(input logic [3:0] i);
      rd = (wb.wr_en && wb.wr_reg == i) ? wb.wr_data : rf[i];
   endfunction

   // Plain always, so the bench may preload the array at time zero
   always @(posedge core_clk) begin
      if (wb.wr_en) begin
         rf[wb.wr_reg] <= wb.wr_data;
      end
   end

   // Idle operand lines carry inverted data, never the last value
   always_comb begin
      issue.valid = req_valid;
      issue.op = req_op;
      issue.condition_true = req_cond;
      issue.dest_given = req_dg;
      issue.dest_reg = req_d;
      issue.first_src_reg = req_n;
      issue.first_val = req_valid ? rd(req_n) : ~rd(req_n);
      issue.second_val = req_valid ? rd(req_m) : ~rd(req_m);
      issue.accum_val = req_valid ? rd(req_a) : ~rd(req_a);
   end
endmodule

// [ssdsu_top.sv]
// Packed SAD and unsigned lane subtract execution unit
`include "ssdsu_params.svh"
module ssdsu_top
   import ssdsu_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire ssdsu_issue_t issue,
   output ssdsu_wb_t wb,
   output logic [`SSDSU_GE_W-1:0] lane_ge_flags,
   output logic bad_reg_use
);
   // ************************************************************
   // Reset release
   // ************************************************************
   logic rst_s1_ff;
   logic rst_s2_ff;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   wire rst_n = rst_s2_ff;

   // ************************************************************
   // Lane arithmetic
   // ************************************************************
   logic [`SSDSU_XLEN-1:0] sub8_res;
   logic [`SSDSU_GE_W-1:0] sub8_ge;
   logic [`SSDSU_XLEN-1:0] sub16_res;
   logic [`SSDSU_GE_W-1:0] sub16_ge;
   logic [`SSDSU_XLEN-1:0] sad_sum;

   ssdsu_lanes u_lanes (
      .a_val(issue.first_val),
      .b_val(issue.second_val),
      .sub8_res(sub8_res),
      .sub8_ge(sub8_ge),
      .sub16_res(sub16_res),
      .sub16_ge(sub16_ge),
      .sad_sum(sad_sum)
   );

   // ************************************************************
   // Operation decode and selection
   // ************************************************************
   logic [`SSDSU_GE_W-1:0] lane_ge_flags_ff;
   logic [`SSDSU_XLEN-1:0] sel_res;
   logic [`SSDSU_XLEN-1:0] sada_sum;
   logic [`SSDSU_XLEN-1:0] nxt_data;
   logic known_op;
   logic sets_ge;

   function automatic logic is_bad_reg(input logic [3:0] r);
      is_bad_reg = (r == `SSDSU_SP_IDX) || (r == `SSDSU_PC_IDX);
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sel
         assign sel_res[gi*8 +: 8] = lane_ge_flags_ff[gi] ?
            issue.first_val[gi*8 +: 8] :
            issue.second_val[gi*8 +: 8];
      end
   endgenerate

   // Modulo 2^32, carry discarded
   assign sada_sum = sad_sum + issue.accum_val;

   always_comb begin
      known_op = 1'b1;
      sets_ge = 1'b0;
      nxt_data = `SSDSU_WORD_ZERO;
      case (issue.op)
         SSDSU_OP_SAD: nxt_data = sad_sum;
         SSDSU_OP_SADA: nxt_data = sada_sum;
         SSDSU_OP_SUB16: begin
            nxt_data = sub16_res;
            sets_ge = 1'b1;
         end
         SSDSU_OP_SUB8: begin
            nxt_data = sub8_res;
            sets_ge = 1'b1;
         end
         SSDSU_OP_SEL: nxt_data = sel_res;
         default: known_op = 1'b0;
      endcase
   end

   wire fire = issue.valid && known_op && issue.condition_true;
   // Accumulating form always names its destination
   wire use_dest = issue.dest_given || (issue.op == SSDSU_OP_SADA);
   wire [`SSDSU_REG_IDX_W-1:0] nxt_reg = use_dest ?
      issue.dest_reg : issue.first_src_reg;
   wire [`SSDSU_GE_W-1:0] nxt_ge =
      (issue.op == SSDSU_OP_SUB16) ? sub16_ge : sub8_ge;
   wire nxt_bad = issue.valid && known_op &&
      (is_bad_reg(nxt_reg) || is_bad_reg(issue.first_src_reg));

   // ************************************************************
   // Writeback and flag registers
   // ************************************************************
   ssdsu_wb_t wb_ff;
   logic bad_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ff <= '0;
         lane_ge_flags_ff <= `SSDSU_GE_RST;
         bad_ff <= 1'b0;
      end else begin
         wb_ff.wr_en <= fire;
         if (fire) begin
            wb_ff.wr_reg <= nxt_reg;
            wb_ff.wr_data <= nxt_data;
         end
         if (fire && sets_ge) begin
            lane_ge_flags_ff <= nxt_ge;
         end
         bad_ff <= nxt_bad;
      end
   end

   assign wb = wb_ff;
   assign lane_ge_flags = lane_ge_flags_ff;
   assign bad_reg_use = bad_ff;

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_sub_issued;
      issue.valid && issue.condition_true &&
      (issue.op == SSDSU_OP_SUB8 || issue.op == SSDSU_OP_SUB16);
   endsequence

   a_ge_hold_sad: assert property (@(posedge core_clk) disable iff (!rst_n)
      (issue.op == SSDSU_OP_SAD || issue.op == SSDSU_OP_SADA)
      |=> $stable(lane_ge_flags))
      else $error("flags moved on SAD");
   a_ge_hold_cond: assert property (@(posedge core_clk) disable iff (!rst_n)
      !issue.condition_true |=> $stable(lane_ge_flags) && !wb.wr_en)
      else $error("failed condition had effect");
   a_sub8_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_sub_issued and issue.op == SSDSU_OP_SUB8 |=>
      lane_ge_flags[0] == ($past(issue.first_val[7:0]) >=
                           $past(issue.second_val[7:0])))
      else $error("byte lane 0 flag wrong");
   a_sub16_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_sub_issued and issue.op == SSDSU_OP_SUB16 |=>
      lane_ge_flags[3:2] == {2{$past(issue.first_val[31:16]) >=
                               $past(issue.second_val[31:16])}})
      else $error("high halfword flags wrong");
   a_sub16_data: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_sub_issued and issue.op == SSDSU_OP_SUB16 |=>
      wb.wr_data[15:0] == 16'($past(issue.first_val[15:0]) -
                              $past(issue.second_val[15:0])))
      else $error("low halfword difference wrong");
   a_sub8_data: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_sub_issued and issue.op == SSDSU_OP_SUB8 |=>
      wb.wr_data[31:24] == 8'($past(issue.first_val[31:24]) -
                              $past(issue.second_val[31:24])))
      else $error("top byte difference wrong");
   a_sad_range: assert property (@(posedge core_clk) disable iff (!rst_n)
      issue.valid && issue.condition_true && issue.op == SSDSU_OP_SAD
      |=> wb.wr_en && wb.wr_data[31:10] == 22'h000000)
      else $error("SAD result too wide");
   a_dest_default: assert property (@(posedge core_clk) disable iff (!rst_n)
      issue.valid && issue.condition_true && !issue.dest_given &&
      issue.op == SSDSU_OP_SUB8
      |=> wb.wr_reg == $past(issue.first_src_reg))
      else $error("default destination wrong");
   a_sada_acc: assert property (@(posedge core_clk) disable iff (!rst_n)
      issue.valid && issue.condition_true && issue.op == SSDSU_OP_SADA &&
      issue.first_val == issue.second_val
      |=> wb.wr_data == $past(issue.accum_val))
      else $error("accumulate wrong");
endmodule

// [testbench.sv]
// Self-checking bench for the packed SAD and lane subtract unit
module testbench
   import ssdsu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic rv = 1'b0, rc = 1'b0, rdg = 1'b0;
   ssdsu_op_t rop = SSDSU_OP_NONE;
   logic [3:0] rd_i = 4'h0, rn = 4'h0, rm = 4'h0, ra = 4'h0;
   ssdsu_issue_t issue;
   ssdsu_wb_t wb;
   logic [3:0] ge;
   logic bad;
   logic [31:0] exp_rf [16];
   logic [3:0] exp_ge = 4'h0;
   int fail_count = 0;
   int cmp_count = 0;

   always #20 core_clk = ~core_clk;

   ssdsu_rf_model u_rf (.core_clk(core_clk), .req_valid(rv), .req_op(rop),
      .req_cond(rc), .req_dg(rdg), .req_d(rd_i), .req_n(rn), .req_m(rm),
      .req_a(ra), .wb(wb), .issue(issue));
   ssdsu_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .issue(issue),
      .wb(wb), .lane_ge_flags(ge), .bad_reg_use(bad));

   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Reference: {flags, result} from the lane rules
   function automatic logic [35:0] ref_op(input ssdsu_op_t op,
      input logic [31:0] a, b, c, input logic [3:0] gi);
      logic [8:0] d8;
      logic [16:0] d16;
      logic [31:0] r;
      logic [3:0] g;
      r = (op == SSDSU_OP_SADA) ? c : 32'h0000_0000;
      g = gi;
      for (int i = 0; i < 4; i++) begin
         d8 = {1'b0, a[8*i+:8]} - {1'b0, b[8*i+:8]};
         if (op == SSDSU_OP_SAD || op == SSDSU_OP_SADA) begin
            r = r + {24'h00_0000, d8[8] ? 8'(-d8[7:0]) : d8[7:0]};
         end else if (op == SSDSU_OP_SUB8) begin
            r[8*i+:8] = d8[7:0];
            g[i] = ~d8[8];
         end else if (op == SSDSU_OP_SEL) begin
            r[8*i+:8] = gi[i] ? a[8*i+:8] : b[8*i+:8];
         end
      end
      for (int i = 0; i < 2; i++) begin
         d16 = {1'b0, a[16*i+:16]} - {1'b0, b[16*i+:16]};
         if (op == SSDSU_OP_SUB16) begin
            r[16*i+:16] = d16[15:0];
            g[2*i+:2] = {2{~d16[16]}};
         end
      end
      ref_op = {g, r};
   endfunction

   task automatic run(input ssdsu_op_t op, input logic c, dg,
      input logic [3:0] d, n, m, a);
      logic [35:0] e;
      logic [3:0] dst;
      logic we;
      e = ref_op(op, exp_rf[n], exp_rf[m], exp_rf[a], exp_ge);
      dst = (dg || op == SSDSU_OP_SADA) ? d : n;
      we = c && op != SSDSU_OP_NONE;
      rv = 1'b1;
      rop = op;
      rc = c;
      rdg = dg;
      rd_i = d;
      rn = n;
      rm = m;
      ra = a;
      @(posedge core_clk);
      #1;
      chk("wr_en", {31'h0, we}, {31'h0, wb.wr_en});
      chk("bad_reg_use", 32'h0, {31'h0, bad});
      if (we) begin
         exp_rf[dst] = e[31:0];
         exp_ge = e[35:32];
         chk("wr_reg", {28'h0, dst}, {28'h0, wb.wr_reg});
         chk("wr_data", e[31:0], wb.wr_data);
      end
      chk("lane_ge_flags", {28'h0, exp_ge}, {28'h0, ge});
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #4000000;
      fail_count++;
      tally_and_finish();
   end

   // ************************************
   // Main sequence
   // ************************************
   initial begin
      exp_rf = '{32'h0, 32'h10FF_0080, 32'h2001_0081, 32'hFFFF_FFF0,
         32'h0, 32'hFFFF_0000, 32'h00FF_FF00, 32'h0, 32'h0, 32'h0,
         32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      foreach (exp_rf[i]) u_rf.rf[i] = exp_rf[i];
      repeat (5) @(posedge core_clk);
      #1;
      chk("wr_en", 32'h0, {31'h0, wb.wr_en});
      arst_n = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      run(SSDSU_OP_SUB8, 1, 1, 7, 1, 2, 0);
      run(SSDSU_OP_SEL, 1, 1, 8, 1, 2, 0);
      run(SSDSU_OP_SUB16, 1, 0, 0, 5, 6, 0);
      run(SSDSU_OP_SAD, 1, 1, 9, 1, 2, 0);
      run(SSDSU_OP_SADA, 1, 0, 10, 1, 2, 3);
      run(SSDSU_OP_SUB8, 0, 1, 11, 2, 1, 0);
      run(SSDSU_OP_SAD, 1, 0, 0, 2, 1, 0);
      run(SSDSU_OP_SUB8, 1, 1, 12, 4, 4, 0);
      run(SSDSU_OP_SUB16, 1, 1, 11, 4, 5, 0);
      run(SSDSU_OP_SUB8, 1, 0, 0, 6, 5, 0);
      run(SSDSU_OP_SADA, 1, 1, 11, 6, 6, 1);
      run(SSDSU_OP_NONE, 1, 1, 11, 1, 2, 0);
      rv = 1'b0;
      @(posedge core_clk);
      #1;
      chk("wr_en", 32'h0, {31'h0, wb.wr_en});
      tally_and_finish();
   end
endmodule
